// *** bsme_chk_monitor.sv ***
`timescale 1ns/1ps
module bsme_chk
  import bsme_pkg::*;
(
  input wire logic clock, rst, int_access, int_write, ext_access, ext_master_dma, ext_cycle_steal, ext_write,
  input wire logic [1:0] int_size,
  input wire logic [BSME_INT_ADDR_W-1:0] int_addr,
  input wire logic [2:0] ext_unit,
  input wire logic [BSME_EXT_ADDR_W-1:0] ext_addr,
  input wire logic [BSME_STATUS_W-1:0] status_pins, status_pin_state,
  input wire logic chan_a_hit, chan_b_hit, bc1_hit, match_clear, snap_req,
  input wire logic [BSME_INT_WORD_W-1:0] internal_bus_state_word,
  input wire logic [BSME_INT_ADDR_W-1:0] internal_bus_address_capture,
  input wire logic [BSME_EXT_WORD_W-1:0] external_bus_state_word,
  input wire logic [BSME_EXT_ADDR_W-1:0] external_bus_address_capture,
  input wire logic chan_a_match_flag, chan_b_match_flag, break_cond1_match_flag
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  property p_int;
    int_access |=> internal_bus_state_word == {1'b1, $past(int_write), $past(int_size)}
      && internal_bus_address_capture == $past(int_addr);
  endproperty
  a_int: assert property (p_int) else $error("internal word wrong");
  property p_int_idle;
    !int_access |=> !internal_bus_state_word[3];
  endproperty
  a_int_idle: assert property (p_int_idle) else $error("internal access bit");
  property p_dma;
    ext_access && ext_master_dma && ext_unit < 3'h5 |=> external_bus_state_word == {$past(ext_unit[2]),
      $past(ext_cycle_steal), 1'b1, $past(ext_unit[1:0]), $past(ext_write), 1'b1};
  endproperty
  a_dma: assert property (p_dma) else $error("dma word wrong");
  property p_cpu;
    ext_access && !ext_master_dma |=> {external_bus_state_word[4], external_bus_state_word[1:0]}
      == {1'b0, $past(ext_write), 1'b1} && external_bus_address_capture == $past(ext_addr);
  endproperty
  a_cpu: assert property (p_cpu) else $error("cpu word wrong");
  property p_ext_idle;
    !ext_access |=> !external_bus_state_word[0];
  endproperty
  a_ext_idle: assert property (p_ext_idle) else $error("external access bit");
  property p_pins;
    $stable(status_pins) [*5] |-> status_pin_state == status_pins;
  endproperty
  a_pins: assert property (p_pins) else $error("pin state late");
  property p_flags;
    chan_a_hit || chan_b_hit |=> chan_a_match_flag >= $past(chan_a_hit) && chan_b_match_flag >= $past(chan_b_hit);
  endproperty
  a_flags: assert property (p_flags) else $error("channel flag missing");
  property p_bc1;
    bc1_hit || (break_cond1_match_flag && !match_clear) |=> break_cond1_match_flag;
  endproperty
  a_bc1: assert property (p_bc1) else $error("bc1 flag lost");
  property p_clear;
    match_clear && !bc1_hit |=> !break_cond1_match_flag;
  endproperty
  a_clear: assert property (p_clear) else $error("bc1 flag kept");
  c_dma: cover property (ext_access && ext_master_dma);
  c_race: cover property (match_clear && chan_a_hit);
  c_snap: cover property (snap_req);
endmodule
bind bsme_monitor bsme_chk u_chk (.clock, .rst, .int_access, .int_write, .ext_access, .ext_master_dma,
  .ext_cycle_steal, .ext_write, .int_size, .int_addr, .ext_unit, .ext_addr, .status_pins, .status_pin_state,
  .chan_a_hit, .chan_b_hit, .bc1_hit, .match_clear, .snap_req, .internal_bus_state_word,
  .internal_bus_address_capture, .external_bus_state_word, .external_bus_address_capture,
  .chan_a_match_flag, .chan_b_match_flag, .break_cond1_match_flag);

// *** bsme_emu.sv ***
`timescale 1ns/1ps
module bsme_emu
  import bsme_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // sampling trigger and snapshot handshake
  input wire logic go,
  output logic snap_req,
  input wire logic snap_ack,
  input wire logic [BSME_INT_WORD_W-1:0] snap_internal_word,
  input wire logic [BSME_EXT_WORD_W-1:0] snap_external_word,
  // decoded sample, invalid fields masked
  output logic [10:0] seen
);
  always_ff @(posedge clock)
  begin
    if (rst)
      snap_req <= 1'b0;
    else
      snap_req <= go;
  end
  always_ff @(posedge clock)
  begin
    if (rst)
      seen <= 11'h000;
    else if (snap_ack)
      seen <= {snap_external_word[0] ? (snap_external_word[4] ? snap_external_word : snap_external_word & 7'h1F) : 7'h00,
               snap_internal_word[3] ? snap_internal_word : 4'h0};
  end
endmodule

// *** bsme_monitor.sv ***
`timescale 1ns/1ps
module bsme_monitor
  import bsme_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // internal load/store bus cycle
  input wire logic int_access,
  input wire logic int_write,
  input wire logic [1:0] int_size,
  input wire logic [BSME_INT_ADDR_W-1:0] int_addr,
  // external bus cycle
  input wire logic ext_access,
  input wire logic ext_master_dma,
  input wire logic ext_cycle_steal,
  input wire logic [2:0] ext_unit,
  input wire logic ext_write,
  input wire logic [BSME_EXT_ADDR_W-1:0] ext_addr,
  // status pins, asynchronous to clock
  input wire logic [BSME_STATUS_W-1:0] status_pins,
  // break unit match events and flag clear
  input wire logic chan_a_hit,
  input wire logic chan_b_hit,
  input wire logic bc1_hit,
  input wire logic match_clear,
  // snapshot request from the emulator side
  input wire logic snap_req,
  output logic snap_ack,
  // live monitored status
  output logic [BSME_INT_WORD_W-1:0] internal_bus_state_word,
  output logic [BSME_INT_ADDR_W-1:0] internal_bus_address_capture,
  output logic [BSME_EXT_WORD_W-1:0] external_bus_state_word,
  output logic [BSME_EXT_ADDR_W-1:0] external_bus_address_capture,
  output logic [BSME_STATUS_W-1:0] status_pin_state,
  output logic chan_a_match_flag,
  output logic chan_b_match_flag,
  output logic break_cond1_match_flag,
  // frozen snapshot of the same fields
  output logic [BSME_INT_WORD_W-1:0] snap_internal_word,
  output logic [BSME_INT_ADDR_W-1:0] snap_internal_addr,
  output logic [BSME_EXT_WORD_W-1:0] snap_external_word,
  output logic [BSME_EXT_ADDR_W-1:0] snap_external_addr,
  output logic [BSME_STATUS_W-1:0] snap_status,
  output logic [2:0] snap_flags
);

  // ****************************************
  // internal word encoding
  // ****************************************
  logic [BSME_INT_WORD_W-1:0] next_int_word;

  always_comb
  begin
    next_int_word = internal_bus_state_word;
    // access marker
    // access valid bit
    next_int_word[BSME_INT_ACC_BIT] = int_access;
    if (int_access)
    begin
      next_int_word[BSME_INT_WR_BIT] = int_write;
      next_int_word[BSME_INT_SZ_LSB +: 2] = int_size;
    end
  end

  // ****************************************
  // external word encoding
  // ****************************************
  logic [BSME_EXT_WORD_W-1:0] next_ext_word;
  logic [2:0] unit_code;

  always_comb
  begin
    // bit 6 only distinguishes 64 bits from 32 bytes; forced low otherwise
    // undefined selector codes fall back to the 64-bit code
    // transfer unit code
    unique case (ext_unit)
      BSME_UNIT_64: unit_code = 3'h0;
      BSME_UNIT_32BYTE: unit_code = 3'h4;
      BSME_UNIT_8: unit_code = 3'h1;
      BSME_UNIT_16: unit_code = 3'h2;
      BSME_UNIT_32: unit_code = 3'h3;
      default: unit_code = 3'h0;
    endcase
  end

  always_comb
  begin
    next_ext_word = external_bus_state_word;
    next_ext_word[BSME_EXT_ACC_BIT] = ext_access;
    if (ext_access)
    begin
      next_ext_word[BSME_EXT_WR_BIT] = ext_write;
      next_ext_word[BSME_EXT_MASTER_BIT] = ext_master_dma;
      next_ext_word[BSME_EXT_UNIT_LSB +: 2] = unit_code[1:0];
      // cpu cycles carry no mode or unit high bit; drive bits 5 and 6 zero so stale dma data cannot leak
      // cpu masks mode
      if (ext_master_dma)
      begin
        next_ext_word[BSME_EXT_MODE_BIT] = ext_cycle_steal;
        next_ext_word[BSME_EXT_UNIT_HI_BIT] = unit_code[2];
      end
      else
      begin
        next_ext_word[BSME_EXT_MODE_BIT] = 1'b0;
        next_ext_word[BSME_EXT_UNIT_HI_BIT] = 1'b0;
      end
    end
  end

  // ****************************************
  // bus state capture
  // ****************************************
  // fields other than the valid bits hold their last access while idle
  // limitation: the emulator must gate stale fields on the valid bits
  // one-edge common load
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      internal_bus_state_word <= BSME_INT_WORD_RST;
      internal_bus_address_capture <= BSME_INT_ADDR_RST;
    end
    else
    begin
      internal_bus_state_word <= next_int_word;
      if (int_access)
      begin
        internal_bus_address_capture <= int_addr;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      external_bus_state_word <= BSME_EXT_WORD_RST;
      external_bus_address_capture <= BSME_EXT_ADDR_RST;
    end
    else
    begin
      external_bus_state_word <= next_ext_word;
      if (ext_access)
      begin
        external_bus_address_capture <= ext_addr;
      end
    end
  end

  // ****************************************
  // status pin synchroniser
  // ****************************************
  // first stage may go metastable; only the later two are ever compared
  logic [BSME_STATUS_W-1:0] pin_meta;
  logic [BSME_STATUS_W-1:0] pin_sync;
  logic [BSME_STATUS_W-1:0] pin_late;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      pin_meta <= BSME_STATUS_RST;
      pin_sync <= BSME_STATUS_RST;
      pin_late <= BSME_STATUS_RST;
    end
    else
    begin
      pin_meta <= status_pins;
      pin_sync <= pin_meta;
      pin_late <= pin_sync;
    end
  end

  // a level is taken only once two stages agree, filtering one-cycle glitches
  // cost: four cycles of latency on every genuine pin change
  // pin level capture
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      status_pin_state <= BSME_STATUS_RST;
    end
    else if (pin_sync == pin_late)
    begin
      status_pin_state <= pin_late;
    end
  end

  // ****************************************
  // break match flags
  // ****************************************
  // one shared clear, since the break unit wipes all flags after a break
  // set beats clear so a hit in the clearing cycle is kept
  // channel a flag
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      chan_a_match_flag <= BSME_BIT_RST;
    end
    else if (chan_a_hit)
    begin
      chan_a_match_flag <= 1'b1;
    end
    else if (match_clear)
    begin
      chan_a_match_flag <= 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      chan_b_match_flag <= BSME_BIT_RST;
    end
    else if (chan_b_hit)
    begin
      chan_b_match_flag <= 1'b1;
    end
    else if (match_clear)
    begin
      chan_b_match_flag <= 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      break_cond1_match_flag <= BSME_BIT_RST;
    end
    else if (bc1_hit)
    begin
      break_cond1_match_flag <= 1'b1;
    end
    else if (match_clear)
    begin
      break_cond1_match_flag <= 1'b0;
    end
  end

  // ****************************************
  // snapshot
  // ****************************************
  // flags packed in the order the emulator reads them
  logic [2:0] live_flags;

  always_comb
  begin
    live_flags = {break_cond1_match_flag, chan_b_match_flag, chan_a_match_flag};
  end

  // copies the registered view in one edge, so every field comes from one cycle
  // coherent snapshot
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      snap_internal_word <= BSME_INT_WORD_RST;
      snap_internal_addr <= BSME_INT_ADDR_RST;
      snap_external_word <= BSME_EXT_WORD_RST;
      snap_external_addr <= BSME_EXT_ADDR_RST;
      snap_status <= BSME_STATUS_RST;
      snap_flags <= BSME_FLAGS_RST;
    end
    else if (snap_req)
    begin
      snap_internal_word <= internal_bus_state_word;
      snap_internal_addr <= internal_bus_address_capture;
      snap_external_word <= external_bus_state_word;
      snap_external_addr <= external_bus_address_capture;
      snap_status <= status_pin_state;
      snap_flags <= live_flags;
    end
  end

  // ack echoes each request cycle; back-to-back requests refresh every cycle
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      snap_ack <= BSME_BIT_RST;
    end
    else
    begin
      snap_ack <= snap_req;
    end
  end

endmodule

// *** bsme_pkg.sv ***
// Contract
// - internal state word bit 2: read is 0, write is 1.
// - internal state word bits 1:0 give width: 8,16,32,64 bits.
// - external word bit 5: dma burst 0, cycle steal 1.
// - external word bit 4: master is cpu 0, dma 1.
// - external bits 6,3,2 encode dma transfer unit, on-chip access size.
// - external word bit 1: read is 0, write is 1.
// - external word bit 0 is 1 while an external access runs.
// - external bit 0 low makes other external bits and address invalid.
// - cpu external access makes bits 5 and 6 invalid.
// - current status pin levels are part of the monitored status.
// - channel a match flag, also reports break condition 6.
// - channel b match flag, also reports break condition 5.
// - break condition 1 flag reads 1 once satisfied.
// - internal bit 3 marks access; low makes rest and address invalid.
package bsme_pkg;
  // ****************************************
  // widths
  // ****************************************
  localparam int BSME_INT_ADDR_W = 32;
  localparam int BSME_EXT_ADDR_W = 29;
  localparam int BSME_STATUS_W = 2;
  localparam int BSME_INT_WORD_W = 4;
  localparam int BSME_EXT_WORD_W = 7;
  // ****************************************
  // internal word field positions
  // ****************************************
  localparam int BSME_INT_ACC_BIT = 3;
  localparam int BSME_INT_WR_BIT = 2;
  localparam int BSME_INT_SZ_LSB = 0;
  // ****************************************
  // external word field positions
  // ****************************************
  localparam int BSME_EXT_UNIT_HI_BIT = 6;
  localparam int BSME_EXT_MODE_BIT = 5;
  localparam int BSME_EXT_MASTER_BIT = 4;
  localparam int BSME_EXT_UNIT_LSB = 2;
  localparam int BSME_EXT_WR_BIT = 1;
  localparam int BSME_EXT_ACC_BIT = 0;
  // ****************************************
  // access width codes
  // ****************************************
  localparam logic [1:0] BSME_SZ_8 = 2'h0;
  localparam logic [1:0] BSME_SZ_16 = 2'h1;
  localparam logic [1:0] BSME_SZ_32 = 2'h2;
  localparam logic [1:0] BSME_SZ_64 = 2'h3;
  // ****************************************
  // dma transfer unit selector, bits {6,3,2}
  // ****************************************
  typedef enum logic [2:0] {
    BSME_UNIT_64 = 3'h0,
    BSME_UNIT_32BYTE = 3'h4,
    BSME_UNIT_8 = 3'h1,
    BSME_UNIT_16 = 3'h2,
    BSME_UNIT_32 = 3'h3
  } bsme_unit_t;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic [BSME_INT_WORD_W-1:0] BSME_INT_WORD_RST = 4'h0;
  localparam logic [BSME_EXT_WORD_W-1:0] BSME_EXT_WORD_RST = 7'h00;
  localparam logic [BSME_INT_ADDR_W-1:0] BSME_INT_ADDR_RST = 32'h00000000;
  localparam logic [BSME_EXT_ADDR_W-1:0] BSME_EXT_ADDR_RST = 29'h00000000;
  localparam logic [BSME_STATUS_W-1:0] BSME_STATUS_RST = 2'h0;
  localparam logic BSME_BIT_RST = 1'h0;
  localparam logic [2:0] BSME_FLAGS_RST = 3'h0;
endpackage

// *** testbench.sv ***
`timescale 1ns/1ps
module testbench;
  import bsme_pkg::*;
  logic clock, rst, int_access, int_write, ext_access, ext_master_dma, ext_cycle_steal, ext_write, go;
  logic chan_a_hit, chan_b_hit, bc1_hit, match_clear, snap_req, snap_ack;
  logic chan_a_match_flag, chan_b_match_flag, break_cond1_match_flag;
  logic [1:0] int_size, status_pins, status_pin_state, snap_status;
  logic [2:0] ext_unit, snap_flags;
  logic [3:0] internal_bus_state_word, snap_internal_word;
  logic [6:0] external_bus_state_word, snap_external_word;
  logic [10:0] seen;
  logic [31:0] int_addr, internal_bus_address_capture, snap_internal_addr;
  logic [28:0] ext_addr, external_bus_address_capture, snap_external_addr;
  int mismatches = 0;
  int n_checks = 0;
  bsme_monitor u_bsme_monitor (.clock, .rst, .int_access, .int_write, .int_size, .int_addr, .ext_access,
    .ext_master_dma, .ext_cycle_steal, .ext_unit, .ext_write, .ext_addr, .status_pins, .chan_a_hit, .chan_b_hit,
    .bc1_hit, .match_clear, .snap_req, .snap_ack, .internal_bus_state_word, .internal_bus_address_capture,
    .external_bus_state_word, .external_bus_address_capture, .status_pin_state, .chan_a_match_flag,
    .chan_b_match_flag, .break_cond1_match_flag, .snap_internal_word, .snap_internal_addr, .snap_external_word,
    .snap_external_addr, .snap_status, .snap_flags);
  bsme_emu u_bsme_emu (.clock, .rst, .go, .snap_req, .snap_ack, .snap_internal_word, .snap_external_word, .seen);
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic t_int;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clock);
      int_access <= 1'b1;
      int_write <= i[2];
      int_size <= i[1:0];
      int_addr <= 32'hA5000000 + 32'(i);
      @(posedge clock);
      int_access <= 1'b0;
      #1;
      check(internal_bus_state_word, {1'b1, i[2], i[1:0]});
      check(internal_bus_address_capture, 32'hA5000000 + 32'(i));
    end
    @(posedge clock);
    #1;
    check(internal_bus_state_word[3], 1'b0);
    check(internal_bus_address_capture, 32'hA5000007);
  endtask
  task automatic t_ext;
    for (int i = 0; i < 12; i++)
    begin
      @(posedge clock);
      ext_access <= 1'b1;
      ext_master_dma <= i < 10;
      ext_cycle_steal <= i[0];
      ext_unit <= i[3:1];
      ext_write <= i[1];
      ext_addr <= 29'h1ABC0000 + 29'(i);
      @(posedge clock);
      ext_access <= 1'b0;
      #1;
      check(external_bus_address_capture, 29'h1ABC0000 + 29'(i));
      if (i < 10)
        check(external_bus_state_word, {i[3], i[0], 1'b1, i[2:1], i[1], 1'b1});
      else
        check({external_bus_state_word[4], external_bus_state_word[1:0]}, {1'b0, i[1], 1'b1});
    end
    @(posedge clock);
    #1;
    check(external_bus_state_word[0], 1'b0);
  endtask
  task automatic t_pins;
    for (int v = 1; v < 4; v++)
    begin
      @(posedge clock);
      status_pins <= v[1:0];
      repeat (6) @(posedge clock);
      #1;
      check(status_pin_state, v[1:0]);
    end
  endtask
  task automatic t_flags;
    for (int k = 0; k < 4; k++)
    begin
      @(posedge clock);
      {bc1_hit, chan_b_hit, chan_a_hit} <= 3'h1 << (k % 3);
      match_clear <= k == 3;
      @(posedge clock);
      {bc1_hit, chan_b_hit, chan_a_hit} <= 3'h0;
      match_clear <= 1'b0;
      repeat (2) @(posedge clock);
      #1;
      check({break_cond1_match_flag, chan_b_match_flag, chan_a_match_flag}, 3'h1 << (k % 3));
      @(posedge clock);
      match_clear <= 1'b1;
      @(posedge clock);
      match_clear <= 1'b0;
      #1;
      check({break_cond1_match_flag, chan_b_match_flag, chan_a_match_flag}, 3'h0);
    end
  endtask
  task automatic t_snap;
    @(posedge clock);
    {int_access, int_write, int_size} <= 4'hF;
    {ext_access, ext_master_dma, ext_cycle_steal, ext_unit, ext_write} <= 7'h78;
    int_addr <= 32'hC0DE0010;
    ext_addr <= 29'h0F00BA00;
    bc1_hit <= 1'b1;
    @(posedge clock);
    bc1_hit <= 1'b0;
    @(posedge clock);
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    @(posedge clock);
    #1;
    check(snap_ack, 1'b1);
    check(snap_internal_addr, 32'hC0DE0010);
    check(snap_external_addr, 29'h0F00BA00);
    check({snap_status, snap_flags}, 5'h1C);
    @(posedge clock);
    {int_access, ext_access} <= 2'h0;
    #1;
    check(snap_ack, 1'b0);
    repeat (2) @(posedge clock);
    #1;
    check(seen, {7'h71, 4'hF});
  endtask
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  initial
  begin
    {rst, int_access, int_write, int_size, int_addr, ext_access, ext_master_dma} = {1'b1, 38'h0};
    {ext_cycle_steal, ext_unit, ext_write, ext_addr, status_pins, go} = 37'h0;
    {chan_a_hit, chan_b_hit, bc1_hit, match_clear} = 4'h0;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    t_int();
    t_ext();
    t_pins();
    t_flags();
    t_snap();
    final_report();
  end
  initial
  begin
    repeat (5000) @(posedge clock);
    mismatches++;
    final_report();
  end
endmodule
